// ==== ibcu_pkg.sv ====
// ibcu_pkg: constants, states and carrier structs of the two-wire bus
// control unit; assumes a 125 MHz clock, no reset assumptions of its own.
package ibcu_pkg;

    localparam int IBCU_CLK_MHZ = 125;
    // low period before a slave releases the clock line after pending rises
    localparam int IBCU_TLOW_NS = 4700;
    localparam int IBCU_TLOW_CYC = (IBCU_TLOW_NS * IBCU_CLK_MHZ + 999) / 1000;
    // half period of the generated bus clock
    localparam int IBCU_HALF_NS = 5000;
    localparam int IBCU_HALF_CYC = (IBCU_HALF_NS * IBCU_CLK_MHZ) / 1000;
    localparam int IBCU_CNT_W = 13;

    localparam logic [1:0] IBCU_MODE_BUS = 2'h2;
    localparam logic [1:0] IBCU_SWR_FIRST = 2'h2;
    localparam logic [1:0] IBCU_SWR_SECOND = 2'h1;
    localparam logic [3:0] IBCU_BITS_WORD = 4'h9;

    typedef enum logic [2:0] {
        IBCU_IDLE,
        IBCU_START,
        IBCU_LOW,
        IBCU_HIGH,
        IBCU_STOP_LOW,
        IBCU_STOP_HIGH
    } ibcu_state_t;

    // software writes to the second control register
    typedef struct packed {
        logic master_sel;
        logic transmit_sel;
        logic bus_busy;
        logic pending;
        logic [1:0] iface_mode_sel;
        logic [1:0] soft_reset_field;
    } ibcu_ctrl2_t;

    // status seen by software
    typedef struct packed {
        logic master_sel;
        logic transmit_sel;
        logic bus_busy;
        logic pending;
        logic arb_lost;
        logic addr_matched;
        logic gencall_seen;
        logic last_rx_bit;
    } ibcu_status_t;

endpackage : ibcu_pkg

// ==== ibcu_core.sv ====
// ibcu_core: control and status logic of the two-wire bus interface.
// assumes open-drain pads outside; scl/sda arrive asynchronously.
// Overview of operation
// RL1: 1111 write when idle emits start and byte
// RL2: bus_busy 0 with 111 requests stop
// RL3: software holds control bits until stop appears
// RL4: start sets bus_busy, stop clears it
// RL5: serial_irq clears pending; pending 0 holds clock
// RL6: word end clears pending; buffer access sets it
// RL7: address or general call match clears pending
// RL8: writing 0 to pending is ignored
// RL9: software selects bus mode with pins high
// RL10: rising clock compares data, mismatch loses arbitration
// RL11: arbitration loss forces slave receiver, stops clock
// RL12: buffer access or control write clears arb_lost
// RL13: addr_matched on match or first free word
// RL14: gencall_seen on eight zeros; start/stop clears
// RL15: last_rx_bit samples data on rising clock
// RL16: 10 then 01 soft reset, then done flag
// RL17: own address recognized only in addressing format
// RL18: software enables baud control before use
// RL19: software programs idle behaviour before halt
// RL20: software initialization gives slave receiver mode
// RL21: master nine clocks, ack sampled, irq, direction
// RL22: slave acknowledges own address on 9th clock
`timescale 1ns/1ps
module ibcu_core
    import ibcu_pkg::*;
#(
    parameter int TLOW_CYC = IBCU_TLOW_CYC,
    parameter int HALF_CYC = IBCU_HALF_CYC
) (
    // clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // control register writes
    input wire logic ctrl2_wr,
    input wire ibcu_pkg::ibcu_ctrl2_t ctrl2_wdata,
    // data buffer access
    input wire logic dbuf_wr,
    input wire logic dbuf_rd,
    input wire logic [7:0] dbuf_wdata,
    // configuration
    input wire logic [6:0] slave_addr,
    input wire logic address_mode_sel,
    input wire logic ack_mode,
    // bus pins, enables low while driving low
    input wire logic scl_in,
    input wire logic sda_in,
    output logic scl_oe_n,
    output logic sda_oe_n,
    // status
    output ibcu_pkg::ibcu_status_t status,
    output logic [1:0] iface_mode_sel,
    output logic [7:0] dbuf_rdata,
    output logic soft_reset_done,
    output logic serial_irq
);
    import ibcu_pkg::*;

    typedef struct packed {
        logic [1:0] scl_s;
        logic [1:0] sda_s;
        logic scl_p;
        logic sda_p;
        ibcu_state_t st;
        logic [IBCU_CNT_W-1:0] cnt;
        logic [3:0] bitn;
        logic [7:0] shreg;
        // direction bit of the address byte, kept apart from the shifter
        logic dir;
        logic [3:0] sbits;
        logic slv_ack;
        logic slv_addr_ph;
        logic sda_drv;
        logic scl_drv;
        logic [IBCU_CNT_W-1:0] rel_cnt;
        logic [1:0] swr_last;
        logic swr_done;
        logic [1:0] mode;
        ibcu_status_t sr;
        logic irq;
    } ibcu_reg_t;

    ibcu_reg_t q, d;

    logic scl, sda, scl_rise, scl_fall, start_ev, stop_ev, acc;
    logic word_end, gcall, own;

    always_comb begin
        d = q;
        scl = q.scl_s[1];
        sda = q.sda_s[1];
        // first stage feeds only the second
        d.scl_s = {q.scl_s[0], scl_in};
        d.sda_s = {q.sda_s[0], sda_in};
        d.scl_p = scl;
        d.sda_p = sda;
        scl_rise = scl && !q.scl_p;
        scl_fall = !scl && q.scl_p;
        start_ev = scl && q.scl_p && q.sda_p && !sda;
        stop_ev = scl && q.scl_p && !q.sda_p && sda;
        acc = dbuf_wr || dbuf_rd;
        d.irq = 1'b0;
        word_end = 1'b0;
        gcall = (q.shreg == 8'h00);
        own = (q.shreg[7:1] == slave_addr) && !address_mode_sel; // RL17

        // bus monitors
        if (start_ev) begin
            d.sr.bus_busy = 1'b1; // RL4
            d.sr.gencall_seen = 1'b0; // RL14
            // the clock fall that closes the start wraps this to zero
            d.sbits = 4'hf;
            d.slv_ack = 1'b0;
            d.slv_addr_ph = 1'b1;
        end else if (stop_ev) begin
            d.sr.bus_busy = 1'b0; // RL4
            d.sr.gencall_seen = 1'b0; // RL14
            d.sr.master_sel = 1'b0;
            d.sr.transmit_sel = 1'b0;
            d.st = IBCU_IDLE;
            d.slv_addr_ph = 1'b0;
            d.sda_drv = 1'b0;
        end
        if (scl_rise) begin
            d.sr.last_rx_bit = sda; // RL15
            // the master sequencer owns the shifter whenever master_sel is set
            if (q.sbits < 4'h8 && !q.sr.master_sel)
                d.shreg = {q.shreg[6:0], sda};
        end
        // arbitration: our output released (1) but line low
        if (scl_rise && q.sr.master_sel && q.sr.transmit_sel
            && !q.sda_drv && !sda && q.bitn < 4'h8) begin
            d.sr.arb_lost = 1'b1; // RL10
            d.sda_drv = 1'b0; // RL10
            d.sr.master_sel = 1'b0; // RL11
            d.sr.transmit_sel = 1'b0; // RL11
            d.scl_drv = 1'b0; // RL11
            d.st = IBCU_IDLE; // RL11
        end
        // slave side word counter on falling edges
        if (scl_fall && !q.sr.master_sel && q.sr.bus_busy) begin
            if (q.sbits == 4'h7) begin
                d.sbits = 4'h8;
                if (q.slv_addr_ph && !address_mode_sel && (own || gcall)) begin
                    d.sda_drv = 1'b1; // RL22
                    d.slv_ack = 1'b1;
                end
            end else if (q.sbits == 4'h8) begin
                d.sbits = 4'h0;
                d.sda_drv = 1'b0;
                if (q.slv_addr_ph) begin
                    d.slv_addr_ph = 1'b0;
                    if (q.slv_ack) begin
                        d.irq = 1'b1; // RL22
                        d.sr.pending = 1'b0; // RL7
                        d.sr.addr_matched = 1'b1; // RL13
                        if (gcall)
                            d.sr.gencall_seen = 1'b1; // RL14
                        else
                            d.sr.transmit_sel = q.shreg[0];
                    end else if (address_mode_sel) begin
                        d.sr.addr_matched = 1'b1; // RL13
                        d.irq = 1'b1;
                        d.sr.pending = 1'b0; // RL6
                    end
                end else if (q.slv_ack) begin
                    d.irq = 1'b1;
                    d.sr.pending = 1'b0; // RL6
                end
            end else begin
                d.sbits = q.sbits + 4'h1;
            end
        end

        // master sequencer
        d.cnt = (q.cnt != '0) ? q.cnt - 1'b1 : '0;
        unique case (q.st)
            IBCU_IDLE: ;
            IBCU_START: if (q.cnt == '0) begin
                d.sda_drv = q.shreg[7] == 1'b0;
                d.dir = q.shreg[0];
                d.scl_drv = 1'b1;
                d.bitn = 4'h0;
                d.cnt = IBCU_CNT_W'(HALF_CYC);
                d.st = IBCU_LOW;
            end
            IBCU_LOW: if (q.cnt == '0 && q.sr.pending) begin
                d.scl_drv = 1'b0;
                d.st = IBCU_HIGH;
                d.cnt = IBCU_CNT_W'(HALF_CYC);
            end
            IBCU_HIGH: if (scl && q.cnt == '0) begin
                d.scl_drv = 1'b1;
                d.cnt = IBCU_CNT_W'(HALF_CYC);
                d.st = IBCU_LOW;
                d.bitn = q.bitn + 4'h1;
                d.shreg = {q.shreg[6:0], 1'b1};
                if (q.bitn == 4'h7)
                    d.sda_drv = !q.sr.transmit_sel && ack_mode;
                else if (q.bitn == IBCU_BITS_WORD - 4'h1) begin
                    word_end = 1'b1; // RL21
                    d.sda_drv = 1'b0;
                    d.bitn = 4'h0;
                end else
                    d.sda_drv = q.sr.transmit_sel && !q.shreg[6];
            end
            IBCU_STOP_LOW: if (q.cnt == '0) begin
                d.scl_drv = 1'b0;
                d.cnt = IBCU_CNT_W'(HALF_CYC);
                d.st = IBCU_STOP_HIGH;
            end
            IBCU_STOP_HIGH: if (scl && q.cnt == '0) begin
                d.sda_drv = 1'b0;
                d.st = IBCU_IDLE;
            end
            default: d.st = IBCU_IDLE;
        endcase
        if (word_end) begin
            d.irq = 1'b1; // RL21
            d.sr.pending = 1'b0; // RL6
            // direction flips only when acknowledged
            if (!sda && q.slv_addr_ph)
                d.sr.transmit_sel = !q.dir; // RL21
            d.slv_addr_ph = 1'b0;
        end
        if (q.irq)
            d.sr.pending = 1'b0; // RL5

        // software accesses
        if (acc) begin
            d.sr.pending = 1'b1; // RL6
            d.sr.arb_lost = 1'b0; // RL12
            d.sr.addr_matched = 1'b0; // RL13
            d.rel_cnt = IBCU_CNT_W'(TLOW_CYC); // RL6
            if (dbuf_wr) begin
                d.shreg = dbuf_wdata;
                if (q.sr.master_sel && q.st == IBCU_LOW)
                    d.sda_drv = q.sr.transmit_sel && !dbuf_wdata[7];
            end
        end else if (q.rel_cnt != '0) begin
            d.rel_cnt = q.rel_cnt - 1'b1;
        end
        if (ctrl2_wr) begin
            d.sr.arb_lost = 1'b0; // RL12
            d.mode = ctrl2_wdata.iface_mode_sel;
            d.swr_last = ctrl2_wdata.soft_reset_field;
            if (ctrl2_wdata.pending) begin
                d.sr.pending = 1'b1; // RL8
                d.rel_cnt = IBCU_CNT_W'(TLOW_CYC);
            end
            if (ctrl2_wdata.master_sel && ctrl2_wdata.transmit_sel
                && ctrl2_wdata.pending) begin
                if (ctrl2_wdata.bus_busy && !q.sr.bus_busy) begin
                    d.sr.master_sel = 1'b1; // RL1
                    d.sr.transmit_sel = 1'b1;
                    d.sda_drv = 1'b1; // RL1
                    d.slv_addr_ph = 1'b1;
                    d.cnt = IBCU_CNT_W'(HALF_CYC);
                    d.st = IBCU_START;
                end else if (!ctrl2_wdata.bus_busy && q.sr.bus_busy) begin
                    d.sda_drv = 1'b1; // RL2
                    d.scl_drv = 1'b1;
                    d.cnt = IBCU_CNT_W'(HALF_CYC);
                    d.st = IBCU_STOP_LOW;
                end
            end
            if (q.swr_last == IBCU_SWR_FIRST
                && ctrl2_wdata.soft_reset_field == IBCU_SWR_SECOND) begin
                d = '0; // RL16
                d.scl_s = q.scl_s;
                d.sda_s = q.sda_s;
                d.scl_p = q.scl_p;
                d.sda_p = q.sda_p;
                d.mode = ctrl2_wdata.iface_mode_sel; // RL16
                d.sr.pending = 1'b1;
                d.swr_done = 1'b1; // RL16
            end
        end
        // pending low holds the clock; slave release waits for the low time after pending rises
        if (!d.sr.pending)
            d.scl_drv = 1'b1; // RL5
        else if (q.rel_cnt == '0 && q.st != IBCU_LOW && q.st != IBCU_STOP_LOW
                 && q.sr.pending && !q.sr.master_sel)
            d.scl_drv = 1'b0; // RL6
        if (q.mode != IBCU_MODE_BUS) begin
            d.scl_drv = 1'b0;
            d.sda_drv = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '0;
            q.scl_s <= 2'h3;
            q.sda_s <= 2'h3;
            q.scl_p <= 1'b1;
            q.sda_p <= 1'b1;
            q.sr.pending <= 1'b1;
            q.st <= IBCU_IDLE;
        end else begin
            q <= d;
        end
    end

    assign scl_oe_n = !q.scl_drv;
    assign sda_oe_n = !q.sda_drv;
    assign status = q.sr;
    assign iface_mode_sel = q.mode;
    assign dbuf_rdata = q.shreg;
    assign soft_reset_done = q.swr_done;
    assign serial_irq = q.irq;

endmodule // ibcu_core

// ==== ibcu_core_asserts.sv ====
// ibcu_core_asserts: port-level checks of the bus control unit
// assumes it is bound onto ibcu_core, one clock domain
`timescale 1ns/1ps
module ibcu_core_asserts
    import ibcu_pkg::*;
#(
    parameter int TLOW_CYC = 8,
    parameter int HALF_CYC = 8
) (
    // clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // software side
    input wire logic ctrl2_wr,
    input wire ibcu_pkg::ibcu_ctrl2_t ctrl2_wdata,
    input wire logic dbuf_wr,
    input wire logic dbuf_rd,
    // bus and status
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic scl_oe_n,
    input wire ibcu_pkg::ibcu_status_t status,
    input wire logic [1:0] iface_mode_sel,
    input wire logic serial_irq
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    logic acc;
    logic bus_on;
    assign acc = dbuf_wr | dbuf_rd;
    assign bus_on = iface_mode_sel == IBCU_MODE_BUS;
    AST_PEND_KEEP: assert property (
        ctrl2_wr && !ctrl2_wdata.pending && status.pending
        |=> status.pending || serial_irq) else $error("pending lost");
    AST_IRQ_PEND: assert property (
        serial_irq && !$past(acc || ctrl2_wr) |-> !status.pending)
        else $error("pending kept at irq");
    AST_SCL_HOLD: assert property (
        !status.pending [*3] && bus_on |-> !scl_oe_n)
        else $error("clock not held");
    // sim runs with a low period of 8 cycles
    AST_TLOW: assert property (
        $rose(status.pending) && !scl_oe_n
        |-> !scl_oe_n [*6] ##[1:12] scl_oe_n) else $error("low period");
    AST_START_BUSY: assert property (
        bus_on && scl_in && $past(scl_in) && $fell(sda_in)
        |-> ##[1:6] status.bus_busy) else $error("start missed");
    AST_STOP_FREE: assert property (
        bus_on && scl_in && $past(scl_in) && $rose(sda_in)
        |-> ##[1:6] !status.bus_busy) else $error("stop missed");
    AST_ARB_SLAVE: assert property (
        $rose(status.arb_lost) |-> !status.master_sel
        && !status.transmit_sel) else $error("still master");
    AST_ARB_CLR: assert property (
        acc || ctrl2_wr |=> !status.arb_lost) else $error("arb kept");
    AST_AAS_CLR: assert property (
        acc |=> !status.addr_matched) else $error("match kept");
    AST_IRQ_PULSE: assert property (
        serial_irq |=> !serial_irq) else $error("irq too long");
endmodule // ibcu_core_asserts

bind ibcu_core ibcu_core_asserts #(.TLOW_CYC(TLOW_CYC), .HALF_CYC(HALF_CYC))
    u_chk (.mclk(mclk), .arst_n(arst_n), .ctrl2_wr(ctrl2_wr),
    .ctrl2_wdata(ctrl2_wdata), .dbuf_wr(dbuf_wr), .dbuf_rd(dbuf_rd),
    .scl_in(scl_in), .sda_in(sda_in), .scl_oe_n(scl_oe_n),
    .status(status), .iface_mode_sel(iface_mode_sel),
    .serial_irq(serial_irq));

// ==== ibcu_bus_peer.sv ====
// ibcu_bus_peer: another master and a slave on the wired-AND bus
// assumes pull-ups on both lines; 160 ns bit time when mastering
`timescale 1ns/1ps
module ibcu_bus_peer #(
    parameter logic [6:0] PEER_ADDR = 7'h50
) (
    // device enables, low while driving
    input wire logic dev_scl_oe_n,
    input wire logic dev_sda_oe_n,
    // resolved lines
    output logic scl,
    output logic sda
);
    logic scl_n = 1'b1;
    logic sda_n = 1'b1;
    logic jam = 1'b0;
    logic ack_n = 1'b1;
    logic last = 1'b1;
    logic [7:0] rx_byte = 8'h00;
    int bits = 9;
    // released lines float up, never keep an old value
    assign scl = dev_scl_oe_n & scl_n;
    assign sda = dev_sda_oe_n & sda_n & ack_n & ~jam;
    always @(negedge sda)
        if (scl)
            bits = 0;
    always @(posedge scl)
        if (bits < 8) begin
            rx_byte = {rx_byte[6:0], sda};
            bits++;
        end else
            bits = 9;
    // acknowledge only our own address, for the 9th clock
    always @(negedge scl)
        ack_n = !(bits == 8 && rx_byte[7:1] == PEER_ADDR);
    // waits for scl high so a device stretching the clock is honoured
    task automatic clk_bit(input logic b);
        sda_n = b;
        #40 scl_n = 1'b1;
        wait (scl === 1'b1);
        #80 last = sda;
        scl_n = 1'b0;
        #40;
    endtask
    task automatic send_byte(input logic [7:0] b, output logic ack);
        sda_n = 1'b0;
        #80 scl_n = 1'b0;
        #40;
        for (int i = 7; i >= 0; i--)
            clk_bit(b[i]);
        clk_bit(1'b1);
        ack = last;
    endtask
    task automatic stop_bus();
        sda_n = 1'b0;
        #40 scl_n = 1'b1;
        wait (scl === 1'b1);
        #80 sda_n = 1'b1;
        #80;
    endtask
endmodule // ibcu_bus_peer

// ==== ibcu_core_tb_top.sv ====
// ibcu_core_tb_top: directed bench of the bus control unit
// assumes the bound checker and the bus peer model
`timescale 1ns/1ps
module ibcu_core_tb_top;
    import ibcu_pkg::*;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic ctrl2_wr = 1'b0;
    ibcu_ctrl2_t ctrl2_wdata = '0;
    logic dbuf_wr = 1'b0;
    logic dbuf_rd = 1'b0;
    logic [7:0] dbuf_wdata = 8'h00;
    logic scl, sda, scl_oe_n, sda_oe_n, soft_reset_done, serial_irq, ack;
    ibcu_status_t status;
    logic [1:0] iface_mode_sel;
    // address byte, expected direction, expected acknowledge bit
    logic [9:0] mc [3] = '{{8'ha0, 2'h2}, {8'h7f, 2'h3}, {8'ha1, 2'h0}};
    logic [7:0] sc [2] = '{8'h74, 8'h00};
    int failures = 0;
    int checks = 0;
    int cyc = 0;
    always #4 mclk = ~mclk;
    ibcu_core #(.TLOW_CYC(8), .HALF_CYC(8)) DUT (
        .mclk(mclk), .arst_n(arst_n), .ctrl2_wr(ctrl2_wr),
        .ctrl2_wdata(ctrl2_wdata), .dbuf_wr(dbuf_wr), .dbuf_rd(dbuf_rd),
        .dbuf_wdata(dbuf_wdata), .slave_addr(7'h3a),
        .address_mode_sel(1'b0), .ack_mode(1'b1), .scl_in(scl),
        .sda_in(sda), .scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n),
        .status(status), .iface_mode_sel(iface_mode_sel), .dbuf_rdata(),
        .soft_reset_done(soft_reset_done), .serial_irq(serial_irq));
    ibcu_bus_peer peer (.dev_scl_oe_n(scl_oe_n), .dev_sda_oe_n(sda_oe_n),
        .scl(scl), .sda(sda));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic wr2(input logic [7:0] v);
        @(negedge mclk);
        ctrl2_wr = 1'b1;
        ctrl2_wdata = v;
        @(negedge mclk);
        ctrl2_wr = 1'b0;
    endtask
    task automatic dbx(input logic wr, input logic [7:0] v);
        @(negedge mclk);
        dbuf_wr = wr;
        dbuf_rd = !wr;
        dbuf_wdata = v;
        @(negedge mclk);
        dbuf_wr = 1'b0;
        dbuf_rd = 1'b0;
    endtask
    // bit 8 is the interrupt pulse, the others index the status
    task automatic wait_on(input int sel, input logic v);
        logic [8:0] s;
        for (int i = 0; i < 4000; i++) begin
            s = {serial_irq, status};
            if (s[sel] === v)
                break;
            @(negedge mclk);
        end
        check({7'h0, s[sel]}, {7'h0, v});
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 40000) begin
            failures++;
            end_sim();
        end
    end
    initial begin
        repeat (16) @(negedge mclk);
        arst_n = 1'b1;
        check(status, 8'h10);
        check({4'h0, scl_oe_n, sda_oe_n, scl, sda}, 8'h0f);
        wr2(8'h18);
        wr2(8'h08);
        check(status, 8'h10);
        check({6'h0, iface_mode_sel}, 8'h02);
        foreach (mc[i]) begin
            repeat (20) @(negedge mclk);
            dbx(1'b1, mc[i][9:2]);
            wr2(8'hf8);
            wait_on(8, 1'b1);
            @(negedge mclk);
            check(status, {1'b1, mc[i][1], 5'h10, mc[i][0]});
            check(peer.rx_byte, mc[i][9:2]);
            check({7'h0, scl_oe_n}, 8'h00);
            wr2(8'hd8);
            wait_on(5, 1'b0);
            check({4'h0, status[7:4]}, 8'h01);
        end
        dbx(1'b1, 8'hff);
        wr2(8'hf8);
        wait_on(5, 1'b1);
        peer.jam = 1'b1;
        wait_on(3, 1'b1);
        check({6'h0, status[7:6]}, 8'h00);
        check({7'h0, sda_oe_n}, 8'h01);
        peer.sda_n = 1'b0;
        peer.jam = 1'b0;
        peer.stop_bus();
        wait_on(5, 1'b0);
        dbx(1'b0, 8'h00);
        check({7'h0, status.arb_lost}, 8'h00);
        foreach (sc[i]) begin
            fork
                peer.send_byte(sc[i], ack);
                wait_on(8, 1'b1);
            join
            @(negedge mclk);
            check({7'h0, ack}, 8'h00);
            check(status, {6'h09, sc[i] == 8'h00, 1'b0});
            dbx(1'b0, 8'h00);
            check({6'h0, status[4], status[2]}, 8'h02);
            peer.stop_bus();
            wait_on(5, 1'b0);
            check({7'h0, status[1]}, 8'h00);
        end
        wr2(8'h1a);
        wr2(8'h19);
        repeat (4) @(negedge mclk);
        check(status, 8'h10);
        check({5'h0, soft_reset_done, iface_mode_sel}, 8'h06);
        end_sim();
    end
endmodule // ibcu_core_tb_top
